// ==== core/hppic_consts.svh ====
// Function
// - per-port switching by default, ganged by configuration
// - ports unpowered after reset until set-power request
// - power-enable active level follows configured polarity
// - overcurrent filtered by timer, 8 ms default
// - filter time 0..15 ms, enabled/disabled ports separate
// - filtered overcurrent reported, port power dropped
// - overcurrent input active level follows configured polarity
// - descriptor bit 7 advertises indicators, set by default
// - configuration can clear indicator-present descriptor bit
// - indicators automatic or manual, automatic at power-up
// - automatic: green when enabled and not suspended, amber on overcurrent
// - automatic mode never blinks the indicators
// - automatic: unpowered amber after overcurrent, else off
// - automatic: green only in enabled/transmit states
// - LED outputs may be square-wave modulated
// - indicator active level follows configured polarity
// - manual: host request sets indicator exactly
// - manual mode supports blinking indicators
// - manual encodings off/amber/green/blinks, green-amber reserved
// - port reset enables connected port, green unless overridden
`ifndef HPPIC_CONSTS_SVH
`define HPPIC_CONSTS_SVH

// ****************************************
// sizes
// ****************************************
`define HP_NPORT 4
`define HP_ADDR_W 8
`define HP_DATA_W 32

// ****************************************
// register byte offsets
// ****************************************
`define HP_OFS_CONFIG 8'h00
`define HP_OFS_OC_TIMER 8'h04
`define HP_OFS_PORT_CMD 8'h08
`define HP_OFS_CONNECT 8'h0C
`define HP_OFS_STATUS 8'h10
`define HP_OFS_HUB_CHAR 8'h14
`define HP_OFS_IND 8'h18

// ****************************************
// reset values
// ****************************************
`define HP_CFG_W 6
`define HP_CFG_RST 6'h00
`define HP_OC_MS_DEF 4'h8
`define HP_TMR_RST 8'h88

// ****************************************
// field positions
// ****************************************
`define HP_CMD_PORT_MSB 1
`define HP_CMD_OP_LSB 4
`define HP_CMD_OP_MSB 6
`define HP_CMD_IND_LSB 8
`define HP_CMD_IND_MSB 10
`define HP_ST_CHG_LSB 16
`define HP_ST_CHG_MSB 19
`define HP_HC_IND_BIT 7

// ****************************************
// port commands
// ****************************************
`define HP_OP_PWR_ON 3'h0
`define HP_OP_PWR_OFF 3'h1
`define HP_OP_RESET 3'h2
`define HP_OP_DISABLE 3'h3
`define HP_OP_SUSPEND 3'h4
`define HP_OP_RESUME 3'h5
`define HP_OP_SET_IND 3'h6

// ****************************************
// indicator selectors
// ****************************************
`define HP_IND_AUTO 3'h0
`define HP_IND_AMBER 3'h1
`define HP_IND_GREEN 3'h2
`define HP_IND_OFF 3'h3
`define HP_IND_BLINK_G 3'h4
`define HP_IND_BLINK_A 3'h5

// ****************************************
// timing
// ****************************************
`define HP_CLK_NS 20
`define HP_MS_NS 1000000
`define HP_MS_CYCLES (`HP_MS_NS / `HP_CLK_NS)
`define HP_BLINK_MS 500
`define HP_BLINK_LAST 9'h1F3

`endif

// ==== core/hppic_oc_filter.sv ====
`timescale 1ns/1ns
`default_nettype none

module hppic_oc_filter
	import hppic_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// ms time base
	input wire logic ms_tick,
	// condition and length
	input wire logic active,
	input wire logic [3:0] limit,
	// filtered result
	output logic tripped
);

	logic [3:0] count; // whole ms seen active

	// ****************************************
	// continuous-activity counter
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			count <= 4'h0;
		end else if (!active) begin
			count <= 4'h0;
		end else if (ms_tick && count < limit) begin
			count <= count + 4'h1;
		end
	end

	// ****************************************
	// trip flag
	// ****************************************
	// a shrinking limit trips at once, limit 0 means no filtering
	always_ff @(posedge clk) begin
		if (reset) begin
			tripped <= 1'b0;
		end else begin
			tripped <= active && (count >= limit);
		end
	end

endmodule // hppic_oc_filter

`default_nettype wire

// ==== core/hppic_pkg.sv ====
`include "hppic_consts.svh"
`default_nettype none

package hppic_pkg;

	// one bit per downstream port
	typedef logic [`HP_NPORT-1:0] hppic_vec_t;

	// manual indicator selector
	typedef logic [2:0] hppic_ind_t;

	// configuration memory settings
	typedef struct packed {
		logic led_mod;    // square-wave led drive
		logic ind_absent; // board has no indicators
		logic led_pol;    // 1: leds active high
		logic oc_pol;     // 1: overcurrent active high
		logic pwr_pol;    // 1: power enable active high
		logic ganged;     // 1: all ports switched together
	} hppic_cfg_s;

	// overcurrent filter lengths in ms
	typedef struct packed {
		logic [3:0] dis_ms; // ports not enabled
		logic [3:0] en_ms;  // enabled ports
	} hppic_tmr_s;

endpackage

`default_nettype wire

// ==== core/hppic_top.sv ====
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "hppic_consts.svh"

module hppic_top
	import hppic_pkg::*;
#(
	parameter int MS_CYCLES = `HP_MS_CYCLES
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// register port
	input wire logic [`HP_ADDR_W-1:0] ADDR,
	input wire logic [`HP_DATA_W-1:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [`HP_DATA_W-1:0] RDATA,
	// power switch pins
	output logic [`HP_NPORT-1:0] PORT_POWER_ENABLE_N,
	input wire logic [`HP_NPORT-1:0] PORT_OVERCURRENT_IN_N,
	// indicator pins
	output logic [`HP_NPORT-1:0] LED_GREEN,
	output logic [`HP_NPORT-1:0] LED_AMBER
);

	// ****************************************
	// helpers
	// ****************************************

	// apply an active level: pol 1 passes, pol 0 inverts
	function automatic hppic_vec_t apply_pol(input hppic_vec_t v,
		input logic pol);
		apply_pol = pol ? v : ~v;
	endfunction

	// port number to one-hot select
	function automatic hppic_vec_t port_onehot(input logic [1:0] p);
		port_onehot = hppic_vec_t'(4'h1 << p);
	endfunction

	// spread one bit to all ports
	function automatic hppic_vec_t spread(input logic b);
		spread = {`HP_NPORT{b}};
	endfunction

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	// ****************************************
	// declarations
	// ****************************************
	hppic_cfg_s cfg;            // configuration settings
	hppic_tmr_s tmr;            // filter lengths
	hppic_vec_t connected;      // attach status from hub core
	hppic_vec_t powered;        // port switch on
	hppic_vec_t enabled;        // port enabled
	hppic_vec_t suspended;      // port suspended
	hppic_vec_t oc_cut;         // power removed by overcurrent
	hppic_vec_t oc_change;      // sticky overcurrent change
	hppic_vec_t manual;         // indicator under host control
	hppic_ind_t ind_code [`HP_NPORT]; // host selector per port
	logic [15:0] ms_count;      // cycles within one ms
	logic ms_tick;              // one-cycle pulse per ms
	logic [8:0] blink_count;    // ms within half blink period
	logic blink_phase;          // blink on/off phase
	logic mod_phase;            // modulation square wave
	hppic_vec_t oc_s1;          // synchroniser stage 1
	hppic_vec_t oc_s2;          // synchroniser stage 2
	hppic_vec_t oc_s3;          // synchroniser stage 3
	hppic_vec_t oc_stable;      // agreed pin level
	hppic_vec_t oc_active;      // overcurrent asserted, raw
	hppic_vec_t oc_valid;       // overcurrent after filter
	hppic_vec_t oc_valid_q;     // previous filter output
	hppic_vec_t oc_drop;        // ports to switch off
	logic cmd_wr;               // port command written
	logic [2:0] cmd_op;         // command code
	hppic_ind_t cmd_ind;        // indicator selector
	hppic_vec_t cmd_sel;        // addressed port
	hppic_vec_t pwr_sel;        // ports hit by power commands
	hppic_vec_t next_green;     // green on, before polarity
	hppic_vec_t next_amber;     // amber on, before polarity
	logic [`HP_DATA_W-1:0] next_rdata; // read mux
	logic [`HP_DATA_W-1:0] hub_char;   // descriptor field
	logic [`HP_DATA_W-1:0] ind_word;   // indicator readback

	// ****************************************
	// command decode
	// ****************************************
	assign cmd_wr = WR_STB && (ADDR == `HP_OFS_PORT_CMD);
	assign cmd_op = WDATA[`HP_CMD_OP_MSB:`HP_CMD_OP_LSB];
	assign cmd_ind = WDATA[`HP_CMD_IND_MSB:`HP_CMD_IND_LSB];
	assign cmd_sel = cmd_wr ? port_onehot(WDATA[`HP_CMD_PORT_MSB:0])
		: '0;
	// ganged: a power request on any port acts on all
	assign pwr_sel = cfg.ganged ? spread(|cmd_sel) : cmd_sel;
	// ganged: one overcurrent takes every port down
	assign oc_drop = cfg.ganged ? spread(|oc_valid) : oc_valid;

	// ****************************************
	// configuration registers
	// ****************************************

	// settings normally loaded from the configuration memory
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			cfg <= `HP_CFG_RST; // per-port by default
		end else if (WR_STB && ADDR == `HP_OFS_CONFIG) begin
			cfg <= hppic_cfg_s'(WDATA[`HP_CFG_W-1:0]);
		end
	end

	// filter lengths, both default to 8 ms
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tmr <= `HP_TMR_RST;
		end else if (WR_STB && ADDR == `HP_OFS_OC_TIMER) begin
			tmr <= hppic_tmr_s'(WDATA[7:0]);
		end
	end

	// attach status mirrored by the hub core
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			connected <= '0;
		end else if (WR_STB && ADDR == `HP_OFS_CONNECT) begin
			connected <= WDATA[`HP_NPORT-1:0];
		end
	end

	// ****************************************
	// time base
	// ****************************************

	// one-cycle enable every millisecond
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ms_count <= 16'h0000;
			ms_tick <= 1'b0;
		end else if (ms_count == MS_LAST) begin
			ms_count <= 16'h0000;
			ms_tick <= 1'b1;
		end else begin
			ms_count <= ms_count + 16'h0001;
			ms_tick <= 1'b0;
		end
	end

	// blink at one toggle per half period
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			blink_count <= 9'h000;
			blink_phase <= 1'b0;
		end else if (ms_tick) begin
			if (blink_count == `HP_BLINK_LAST) begin
				blink_count <= 9'h000;
				blink_phase <= ~blink_phase;
			end else begin
				blink_count <= blink_count + 9'h001;
			end
		end
	end

	// 50 % square wave for led power saving
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			mod_phase <= 1'b0;
		end else if (ms_tick) begin
			mod_phase <= ~mod_phase;
		end
	end

	// ****************************************
	// overcurrent inputs
	// ****************************************

	// three stages; stage 1 feeds stage 2 only
	// stages start at the idle pin level, so reset makes no false edge
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			oc_s1 <= '1;
			oc_s2 <= '1;
			oc_s3 <= '1;
		end else begin
			oc_s1 <= PORT_OVERCURRENT_IN_N;
			oc_s2 <= oc_s1;
			oc_s3 <= oc_s2;
		end
	end

	// accept a change once the last two stages agree
	// reset value is the idle level of the reset polarity (high)
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			oc_stable <= '1;
		end else begin
			for (int i = 0; i < `HP_NPORT; i++) begin
				if (oc_s2[i] == oc_s3[i]) begin
					oc_stable[i] <= oc_s3[i];
				end
			end
		end
	end

	assign oc_active = apply_pol(oc_stable, cfg.oc_pol);

	// one filter per port, length chosen by enable state
	for (genvar g = 0; g < `HP_NPORT; g++) begin : g_filt
		hppic_oc_filter u_filt (
			.clk(CLK_SYS),
			.reset(RESET),
			.ms_tick(ms_tick),
			.active(oc_active[g]),
			.limit(enabled[g] ? tmr.en_ms : tmr.dis_ms),
			.tripped(oc_valid[g])
		);
	end

	// previous filter output, for change detection
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			oc_valid_q <= '0;
		end else begin
			oc_valid_q <= oc_valid;
		end
	end

	// ****************************************
	// port state
	// ****************************************

	// power held off while a filtered overcurrent stands
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			powered <= '0;
		end else begin
			powered <= ((powered | (cmd_op == `HP_OP_PWR_ON ? pwr_sel
				: '0)) & ~(cmd_op == `HP_OP_PWR_OFF ? pwr_sel : '0))
				& ~oc_drop;
		end
	end

	// remembers that overcurrent removed power, for amber
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			oc_cut <= '0;
		end else begin
			oc_cut <= (oc_cut & ~(cmd_op == `HP_OP_PWR_ON ? pwr_sel
				: '0)) | (oc_drop & powered);
		end
	end

	// reset request enables a powered, connected port
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			enabled <= '0;
		end else begin
			enabled <= (enabled | (cmd_op == `HP_OP_RESET ? cmd_sel
				: '0)) & ~(cmd_op == `HP_OP_DISABLE ? cmd_sel : '0)
				& connected & powered & ~oc_drop;
		end
	end

	// suspend only meaningful on an enabled port
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			suspended <= '0;
		end else begin
			suspended <= (suspended | (cmd_op == `HP_OP_SUSPEND ? cmd_sel
				: '0)) & ~(cmd_op == `HP_OP_RESUME ? cmd_sel : '0)
				& enabled;
		end
	end

	// change flags; a new edge beats a clearing write
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			oc_change <= '0;
		end else begin
			oc_change <= (oc_change & ~((WR_STB && ADDR == `HP_OFS_STATUS)
				? WDATA[`HP_ST_CHG_MSB:`HP_ST_CHG_LSB] : '0))
				| (oc_valid ^ oc_valid_q);
		end
	end

	// ****************************************
	// indicator selection
	// ****************************************

	// host selector; reserved green/amber blink is refused
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			manual <= '0;
			for (int i = 0; i < `HP_NPORT; i++) begin
				ind_code[i] <= `HP_IND_OFF;
			end
		end else if (cmd_op == `HP_OP_SET_IND) begin
			for (int i = 0; i < `HP_NPORT; i++) begin
				if (cmd_sel[i] && cmd_ind == `HP_IND_AUTO) begin
					manual[i] <= 1'b0;
				end else if (cmd_sel[i] && cmd_ind <= `HP_IND_BLINK_A)
				begin
					manual[i] <= 1'b1;
					ind_code[i] <= cmd_ind;
				end
			end
		end
	end

	// colour per port, then modulation, before polarity
	always_comb begin
		next_green = '0;
		next_amber = '0;
		for (int i = 0; i < `HP_NPORT; i++) begin
			if (cfg.ind_absent) begin
				// no leds fitted, keep lines idle
				next_green[i] = 1'b0;
			end else if (manual[i]) begin
				unique case (ind_code[i])
					`HP_IND_AMBER: next_amber[i] = 1'b1;
					`HP_IND_GREEN: next_green[i] = 1'b1;
					`HP_IND_BLINK_G: next_green[i] = blink_phase;
					`HP_IND_BLINK_A: next_amber[i] = blink_phase;
					default: next_green[i] = 1'b0; // off
				endcase
			end else if (!powered[i]) begin
				next_amber[i] = oc_cut[i];
			end else if (oc_valid[i]) begin
				next_amber[i] = 1'b1;
			end else begin
				// steady, never blink phase here
				next_green[i] = enabled[i] & ~suspended[i];
			end
		end
		if (cfg.led_mod) begin
			next_green = next_green & spread(mod_phase);
			next_amber = next_amber & spread(mod_phase);
		end
	end

	// ****************************************
	// pin outputs
	// ****************************************

	// every pin from a flip-flop, polarity applied last
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			PORT_POWER_ENABLE_N <= '1; // off at default polarity
			LED_GREEN <= '1;
			LED_AMBER <= '1;
		end else begin
			PORT_POWER_ENABLE_N <= apply_pol(powered, cfg.pwr_pol);
			LED_GREEN <= apply_pol(next_green, cfg.led_pol);
			LED_AMBER <= apply_pol(next_amber, cfg.led_pol);
		end
	end

	// ****************************************
	// register reads
	// ****************************************

	// descriptor characteristics as the hub core reports them
	assign hub_char = {24'h000000, ~cfg.ind_absent, 2'b00,
		cfg.ganged ? 2'b00 : 2'b01, 1'b0,
		cfg.ganged ? 2'b00 : 2'b01};

	// per port: manual flag above three selector bits
	always_comb begin
		ind_word = '0;
		for (int i = 0; i < `HP_NPORT; i++) begin
			ind_word[4*i +: 4] = {manual[i], ind_code[i]};
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		unique case (ADDR)
			`HP_OFS_CONFIG: next_rdata = {26'h0, cfg};
			`HP_OFS_OC_TIMER: next_rdata = {24'h000000, tmr};
			`HP_OFS_CONNECT: next_rdata = {28'h0000000, connected};
			`HP_OFS_STATUS: next_rdata = {8'h00, manual, oc_change,
				oc_valid, suspended, enabled, powered};
			`HP_OFS_HUB_CHAR: next_rdata = hub_char;
			`HP_OFS_IND: next_rdata = ind_word;
			default: next_rdata = 32'h00000000;
		endcase
	end

	// data valid only in the cycle after the strobe
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			RDATA <= 32'h00000000;
		end else if (RD_STB) begin
			RDATA <= next_rdata;
		end else begin
			RDATA <= 32'h00000000;
		end
	end

endmodule // hppic_top

`default_nettype wire

// ==== tb/hppic_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hppic_consts.svh"

module hppic_sva
	import hppic_pkg::*;
#(
	parameter int MS_CYCLES = 10
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// register port
	input wire logic [`HP_ADDR_W-1:0] ADDR,
	input wire logic [`HP_DATA_W-1:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire logic [`HP_DATA_W-1:0] RDATA,
	// switch and indicator pins
	input wire logic [`HP_NPORT-1:0] PORT_POWER_ENABLE_N,
	input wire logic [`HP_NPORT-1:0] PORT_OVERCURRENT_IN_N,
	input wire logic [`HP_NPORT-1:0] LED_GREEN,
	input wire logic [`HP_NPORT-1:0] LED_AMBER
);
	// ****************************************
	// shadow state rebuilt from bus writes
	// ****************************************
	localparam int OC_BOUND = 16 * MS_CYCLES + 12; // longest filter plus sync
	hppic_cfg_s cfg; // config as the design holds it
	hppic_cfg_s cfg_d1; // one edge older
	hppic_cfg_s cfg_d2; // two edges older, pins lag by up to this
	logic any_on; // some power-on request seen
	logic [31:0] run [4]; // cycles of unbroken overcurrent
	logic [3:0] oc_act, pwr_act, lit_g, lit_a, over, off_req;
	// config shadow
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			cfg <= '0;
		else if (WR_STB && ADDR == `HP_OFS_CONFIG)
			cfg <= WDATA[5:0];
		cfg_d1 <= cfg;
		cfg_d2 <= cfg_d1;
	end
	// power-on request seen
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			any_on <= 1'h0;
		else if (WR_STB && ADDR == `HP_OFS_PORT_CMD &&
			WDATA[6:4] == `HP_OP_PWR_ON)
			any_on <= 1'h1;
	end
	// a polarity change restarts the runs, the old level is meaningless
	always_ff @(posedge CLK_SYS) begin
		for (int i = 0; i < 4; i++) begin
			if (RESET || cfg != cfg_d1 || !oc_act[i])
				run[i] <= '0;
			else if (run[i] <= OC_BOUND)
				run[i] <= run[i] + 32'h1;
		end
	end
	// pin levels turned into meanings
	always_comb begin
		oc_act = ~(PORT_OVERCURRENT_IN_N ^ {4{cfg.oc_pol}});
		pwr_act = ~(PORT_POWER_ENABLE_N ^ {4{cfg_d1.pwr_pol}});
		lit_g = ~(LED_GREEN ^ {4{cfg_d1.led_pol}});
		lit_a = ~(LED_AMBER ^ {4{cfg_d1.led_pol}});
		for (int i = 0; i < 4; i++)
			over[i] = run[i] > OC_BOUND;
		off_req = 4'h0;
		if (WR_STB && ADDR == `HP_OFS_PORT_CMD && WDATA[6:4] == `HP_OP_PWR_OFF)
			off_req = 4'h1 << WDATA[1:0];
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	a_reset_dark: assert property (
		$fell(RESET) |-> PORT_POWER_ENABLE_N == 4'hF && LED_GREEN == 4'hF
		&& LED_AMBER == 4'hF) else $error("outputs not idle after reset");
	a_rdata_idle: assert property (
		!$past(RD_STB) |-> RDATA == '0) else $error("read data without read");
	a_unmapped_zero: assert property (
		$past(RD_STB) && $past(ADDR) > 8'h18 |-> RDATA == '0)
		else $error("unmapped read not zero");
	a_hubchar_bits: assert property (
		$past(RD_STB) && $past(ADDR) == `HP_OFS_HUB_CHAR |->
		RDATA[`HP_HC_IND_BIT] == !cfg_d1.ind_absent &&
		RDATA[1:0] == {1'h0, !cfg_d1.ganged}) else $error("hub char wrong");
	a_unpowered_start: assert property (
		!$past(any_on) && cfg_d1 == cfg_d2 |-> pwr_act == 4'h0)
		else $error("port powered without request");
	a_power_off_cmd: assert property (
		off_req != 4'h0 |-> ##3 (pwr_act & $past(off_req, 3)) == 4'h0)
		else $error("power off request not obeyed");
	a_dark_absent: assert property (
		cfg_d1 == cfg_d2 && cfg_d1.ind_absent |-> (lit_g | lit_a) == 4'h0)
		else $error("lamp lit with indicators absent");
	a_colours_excl: assert property (
		cfg_d1 == cfg_d2 |-> (lit_g & lit_a) == 4'h0)
		else $error("green and amber lit together");
	a_oc_trip_bound: assert property (
		cfg_d1 == cfg_d2 |-> (over & pwr_act) == 4'h0)
		else $error("overcurrent not cut in time");
endmodule // hppic_sva

bind hppic_top hppic_sva #(.MS_CYCLES(MS_CYCLES)) hppic_sva_inst (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
	.PORT_POWER_ENABLE_N(PORT_POWER_ENABLE_N),
	.PORT_OVERCURRENT_IN_N(PORT_OVERCURRENT_IN_N),
	.LED_GREEN(LED_GREEN), .LED_AMBER(LED_AMBER));

`default_nettype wire

// ==== tb/hppic_switch_model.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hppic_consts.svh"

module hppic_switch_model
	import hppic_pkg::*;
(
	// clock
	input wire logic clk,
	// pins from the hub
	input wire logic [3:0] pwr_pin,
	input wire logic [3:0] led_green,
	input wire logic [3:0] led_amber,
	// board strapping and injected faults
	input wire hppic_cfg_s cfg,
	input wire logic [3:0] fault,
	// switch flags and visible lamps
	output logic [3:0] oc_pin,
	output logic [3:0] lit_green,
	output logic [3:0] lit_amber
);
	logic [3:0] powered; // switch outputs live
	logic [3:0] flag = 4'h0; // switch reports overload
	assign powered = ~(pwr_pin ^ {4{cfg.pwr_pol}});
	// a dead output draws nothing, so it cannot flag
	always_ff @(posedge clk) begin
		flag <= fault & powered;
	end
	assign oc_pin = cfg.oc_pol ? flag : ~flag;
	assign lit_green = ~(led_green ^ {4{cfg.led_pol}});
	assign lit_amber = ~(led_amber ^ {4{cfg.led_pol}});
endmodule // hppic_switch_model

`default_nettype wire

// ==== tb/hub_port_power_indicator_ctrl_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hppic_consts.svh"

module hub_port_power_indicator_ctrl_bench
	import hppic_pkg::*;
;
	// ****************************************
	// signals and reference state
	// ****************************************
	localparam int MS = 10; // short ms keeps the run brief
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'h0;
	logic rd_stb = 1'h0;
	logic [31:0] rdata, rv;
	logic [3:0] port_power_enable_n, oc_n, led_g, led_a, lit_g, lit_a;
	logic [3:0] fault = 4'h0; // overloads to inject
	hppic_cfg_s cfg = '0; // board strapping, mirrors CONFIG
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 49;
	int pow, en, susp, amb; // reference port state, one bit a port
	int sel [4] = '{0, 0, 0, 0}; // reference selectors, 0 auto
	always #10 clk = ~clk;
	hppic_top #(.MS_CYCLES(MS)) hppic_top_inst (.CLK_SYS(clk),
		.RESET(reset), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
		.RD_STB(rd_stb), .RDATA(rdata), .PORT_POWER_ENABLE_N(port_power_enable_n),
		.PORT_OVERCURRENT_IN_N(oc_n), .LED_GREEN(led_g), .LED_AMBER(led_a));
	hppic_switch_model hppic_switch_model_inst (.clk(clk), .pwr_pin(port_power_enable_n),
		.led_green(led_g), .led_amber(led_a), .cfg(cfg), .fault(fault),
		.oc_pin(oc_n), .lit_green(lit_g), .lit_amber(lit_a));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'h1;
		@(posedge clk);
		wr_stb <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'h1;
		@(posedge clk);
		rd_stb <= 1'h0;
		#1 rv = rdata;
		chk(rv, e);
	endtask
	task automatic cmd(input int p, input int op, input int s);
		wr(`HP_OFS_PORT_CMD, {21'h0, s[2:0], 1'h0, op[2:0], 2'h0, p[1:0]});
	endtask
	// expected pins from the reference state; blinking is checked apart
	task automatic cp();
		logic [3:0] g, a;
		g = 4'h0;
		a = 4'h0;
		for (int p = 0; p < 4; p++) begin
			if (sel[p] == 1)
				a[p] = 1'h1;
			else if (sel[p] == 2)
				g[p] = 1'h1;
			else if (sel[p] == 0 && !pow[p])
				a[p] = amb[p];
			else if (sel[p] == 0)
				g[p] = en[p] & !susp[p];
		end
		if (cfg.ind_absent) begin
			g = 4'h0;
			a = 4'h0;
		end
		tick(3);
		#1 chk({20'h0, port_power_enable_n, led_g, led_a}, {20'h0,
			pow[3:0] ^ {4{!cfg.pwr_pol}}, g ^ {4{!cfg.led_pol}},
			a ^ {4{!cfg.led_pol}}});
	endtask
	task automatic setcfg(input logic [5:0] v);
		wr(`HP_OFS_CONFIG, {26'h0, v});
		#1 cfg = v;
		rdc(`HP_OFS_CONFIG, {26'h0, v});
		cp();
	endtask
	// hold an overload until the port is cut, bounded
	task automatic trip(input int p);
		@(posedge clk);
		fault[p] <= 1'h1;
		repeat (200) begin
			@(posedge clk);
			if (port_power_enable_n[p] !== cfg.pwr_pol)
				break;
		end
		fault[p] <= 1'h0;
		pow[p] = 0;
		en[p] = 0;
		amb[p] = 1;
		cp();
	endtask
	// sample port 0 for 1100 ms: one colour must toggle, the other stay dark
	task automatic blink(input int s);
		int on, bad;
		cmd(0, `HP_OP_SET_IND, s);
		on = 0;
		bad = 0;
		repeat (220) begin
			tick(5 * MS);
			on += (s == 4) ? lit_g[0] : lit_a[0];
			bad += (s == 4) ? lit_a[0] : lit_g[0];
		end
		chk({31'h0, on > 60 && on < 160}, 32'h1);
		chk(bad, 32'h0);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		pow = 0;
		en = 0;
		susp = 0;
		amb = 0;
		tick(12);
		reset <= 1'h0;
		cp();
		rdc(`HP_OFS_CONFIG, 32'h0);
		rdc(`HP_OFS_OC_TIMER, 32'h88);
		rdc(`HP_OFS_HUB_CHAR, 32'h89);
		rdc(`HP_OFS_IND, 32'h3333);
		rdc(`HP_OFS_STATUS, 32'h0);
		wr(8'h20, $random(seed));
		rdc(8'h20, 32'h0);
		wr(`HP_OFS_OC_TIMER, 32'h23);
		rdc(`HP_OFS_OC_TIMER, 32'h23);
		wr(`HP_OFS_CONNECT, 32'hF);
		for (int p = 0; p < 4; p++) begin
			cmd(p, `HP_OP_PWR_ON, 0);
			pow[p] = 1;
			cp();
		end
		// port 1 through enable, suspend, resume, disable
		cmd(1, `HP_OP_RESET, 0);
		en = 2;
		cp();
		cmd(1, `HP_OP_SUSPEND, 0);
		susp = 2;
		cp();
		cmd(1, `HP_OP_RESUME, 0);
		susp = 0;
		cp();
		cmd(1, `HP_OP_DISABLE, 0);
		en = 0;
		cp();
		cmd(1, `HP_OP_RESET, 0);
		en = 2;
		cp();
		// a short overload must not cut the port
		@(posedge clk);
		fault <= 4'h2;
		tick(2 + ($random(seed) & 3));
		fault <= 4'h0;
		tick(30);
		cp();
		trip(1);
		tick(4);
		rdc(`HP_OFS_STATUS, 32'h0002000D);
		chk({28'h0, rv[19:16]}, 32'h2);
		// change flag clears by writing one to it
		wr(`HP_OFS_STATUS, 32'h00020000);
		rdc(`HP_OFS_STATUS, 32'h0000000D);
		// inverted polarities, then an overload on an idle port
		setcfg(6'hE);
		cmd(3, `HP_OP_PWR_OFF, 0);
		pow[3] = 0;
		cp();
		trip(2);
		for (int s = 1; s < 4; s++) begin
			cmd(0, `HP_OP_SET_IND, s);
			sel[0] = s;
			cp();
			rdc(`HP_OFS_IND, 32'h3338 + s);
		end
		cmd(0, `HP_OP_SET_IND, 6);
		rdc(`HP_OFS_IND, 32'h333B);
		blink(4);
		blink(5);
		// square-wave drive: a steady green is lit about half the time
		cmd(0, `HP_OP_SET_IND, 2);
		wr(`HP_OFS_CONFIG, 32'h2E);
		#1 cfg = 6'h2E;
		rv = 0;
		repeat (40) begin
			tick(1);
			rv += lit_g[0];
		end
		chk({31'h0, rv > 12 && rv < 28}, 32'h1);
		wr(`HP_OFS_CONFIG, 32'hE);
		#1 cfg = 6'hE;
		cmd(0, `HP_OP_SET_IND, 0);
		sel[0] = 0;
		cp();
		// ganged switching acts on every port
		setcfg(6'hF);
		rdc(`HP_OFS_HUB_CHAR, 32'h80);
		cmd(0, `HP_OP_PWR_OFF, 0);
		pow = 0;
		en = 0;
		cp();
		cmd(2, `HP_OP_PWR_ON, 0);
		pow = 15;
		cp();
		setcfg(6'h1F);
		rdc(`HP_OFS_HUB_CHAR, 32'h0);
		wrap_up();
	end
	// hang guard, well past the planned run
	initial begin
		tick(80000);
		n_mismatch++;
		wrap_up();
	end
endmodule // hub_port_power_indicator_ctrl_bench

`default_nettype wire
